// ---- verilog/flash_host_pkg.sv ----
// Purpose: Constants and types shared by the parallel flash host controller.
// Assumes: 16-bit word device, 23 word address lines, 40 MHz system clock.
// Notes:   Timing figures are in ns; cycle counts are derived from the clock rate.
package flash_host_pkg;
   localparam int ADDR_W        = 23;          // Word address width
   localparam int DATA_W        = 16;          // Word data width
   localparam int CLK_NS        = 25;          // System clock period
   localparam int PAGE_LSB_W    = 3;           // Word-in-page field width
   localparam int BANK_W        = 3;           // Bank field width at the top of the address
   // Access times, as printed for the fastest grade
   localparam int T_ACC_NS      = 55;          // Random / chip-select access
   localparam int T_PACC_NS     = 20;          // In-page access
   localparam int T_WP_NS       = 35;          // Write strobe low width (chosen)
   localparam int T_WPH_NS      = 25;          // Write strobe high recovery (chosen)
   // Least times round up to whole cycles
   localparam int ACC_CYC   = (T_ACC_NS  + CLK_NS - 1) / CLK_NS + 1;
   localparam int PACC_CYC  = (T_PACC_NS + CLK_NS - 1) / CLK_NS + 1;
   localparam int WP_CYC    = (T_WP_NS   + CLK_NS - 1) / CLK_NS;
   localparam int WPH_CYC   = (T_WPH_NS  + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W     = 4;               // Wait counter width
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   // Bank codes from the top three address bits
   localparam logic [BANK_W-1:0] BANK_A_CODE = 3'h0;
   localparam logic [BANK_W-1:0] BANK_D_CODE = 3'h7;
   localparam logic [BANK_W-1:0] BANK_C_LOW  = 3'h4;
   localparam logic [1:0] BANK_A = 2'h0;
   localparam logic [1:0] BANK_B = 2'h1;
   localparam logic [1:0] BANK_C = 2'h2;
   localparam logic [1:0] BANK_D = 2'h3;
   // Operation requests from the user side
   typedef enum logic [1:0] {
      OP_READ    = 2'h0,
      OP_WRITE   = 2'h1,
      OP_NONE    = 2'h2
   } op_type;
   // Bus sequencer states, Gray coded out of idle along the read and write paths; each return to idle changes two bits
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_RWAIT  = 3'h1,
      ST_RDONE  = 3'h3,
      ST_WLOW   = 3'h2,
      ST_WHIGH  = 3'h6
   } state_type;
endpackage

// ---- verilog/flash_bank_decode.sv ----
// Purpose: Decode the bank from the top address bits and spot page hits.
// Assumes: Pure combinational, same clock domain as the caller.
// Notes:   A page hit needs an open page; the caller closes it on deselect.
`timescale 1ns/1ps
module flash_bank_decode
   import flash_host_pkg::*;
(
   input  wire logic [ADDR_W-1:0] addr,       // Requested word address
   input  wire logic [ADDR_W-1:0] open_addr,  // Address of the open page
   input  wire logic              page_open,  // A page is held open
   output logic      [1:0]        bank,       // Bank index A..D
   output logic                   page_hit    // Same page as the open one
);
   logic [BANK_W-1:0] top;  // Bank field

   // Bank select table
   always_comb begin
      top = addr[ADDR_W-1 -: BANK_W];
      if (top == BANK_A_CODE) begin
         bank = BANK_A;
      end else if (top == BANK_D_CODE) begin
         bank = BANK_D;
      end else if (top < BANK_C_LOW) begin
         bank = BANK_B;
      end else begin
         bank = BANK_C;
      end
      // Upper bits from bit 3 select the page
      page_hit = page_open &&
                 (addr[ADDR_W-1:PAGE_LSB_W] == open_addr[ADDR_W-1:PAGE_LSB_W]);
   end
endmodule

// ---- verilog/flash_host_ctrl.sv ----
// Purpose: Host controller driving an asynchronous 16-bit parallel flash.
// Assumes: One clock; the flash has no clock; ready_busy_out is open drain.
// Notes:   Reads wait full or page access time; writes are strobed cycles.
//
// Contract
// - Read: chip select, output enable low
// - Write: strobe, chip select low, enable high
// - Accelerate voltage only for bypass programs; here raised whenever accel_req is set and no read is open
// - Protect pin high for edge sector writes
// - Protect pin never left floating
`timescale 1ns/1ps
module flash_host_ctrl
   import flash_host_pkg::*;
(
   input  wire logic                     clk_sys,       // System clock, 40 MHz
   input  wire logic                     rst,           // Synchronous reset, active high
   input  wire flash_host_pkg::op_type   req_op,        // Requested operation
   input  wire logic                     req_valid,     // Request strobe, one cycle
   input  wire logic [flash_host_pkg::ADDR_W-1:0] req_addr, // Word address
   input  wire logic [flash_host_pkg::DATA_W-1:0] req_wdata, // Write word
   input  wire logic                     accel_req,     // Ask for accelerated programming
   input  wire logic                     protect_req,   // Ask to guard edge sectors
   input  wire logic                     flash_reset_req, // Hold the flash in reset
   output logic                          req_ready,     // Able to take a request
   output logic                          rsp_valid,     // Read data valid, one cycle
   output logic [flash_host_pkg::DATA_W-1:0] rsp_rdata, // Read word
   output logic [1:0]                    rsp_bank,      // Bank of the last access
   output logic                          flash_ready,   // Filtered ready/busy level
   output logic [flash_host_pkg::ADDR_W-1:0] word_address_lines, // Address pins
   output logic                          chip_sel_n,    // Chip select, active low
   output logic                          out_en_n,      // Output enable, active low
   output logic                          wr_strobe_n,   // Write strobe, active low
   output logic                          reset_n,       // Flash reset pin, active low
   output logic                          protect_accel_pin, // Logic-level protect pin
   output logic                          accel_high_voltage, // Enables high-voltage switch
   output logic [flash_host_pkg::DATA_W-1:0] word_data_lines_o,  // Data out
   output logic                          word_data_lines_oe, // High while host drives
   input  wire logic [flash_host_pkg::DATA_W-1:0] word_data_lines_i, // Data in
   input  wire logic                     ready_busy_out // Ready/busy pin from flash
);
   state_type               st_q, st_d;          // Sequencer state
   logic [CNT_W-1:0]        cnt_q, cnt_d;        // Access wait counter
   logic [ADDR_W-1:0]       addr_q, addr_d;      // Address pins register
   logic [ADDR_W-1:0]       open_q, open_d;      // Open page address
   logic                    popen_q, popen_d;    // Page open flag
   logic [DATA_W-1:0]       wd_q, wd_d;          // Write data register
   logic [DATA_W-1:0]       rd_q, rd_d;          // Read data register
   logic                    oe_q, oe_d;          // Data drive enable
   logic                    cs_q, cs_d;          // Chip select, active high inside
   logic                    rdq_q, rdq_d;        // Output enable, active high inside
   logic                    wr_q, wr_d;          // Write strobe, active high inside
   logic                    vld_q, vld_d;        // Response valid
   logic                    rdy_q, rdy_d;        // Request ready
   logic [1:0]              bank_q, bank_d;      // Last bank
   logic                    rst_pin_q, rst_pin_d; // Flash reset driven
   logic                    wp_q, wp_d;          // Protect pin level
   logic                    hv_q, hv_d;          // High voltage enable
   logic [2:0]              rb_sync_q;           // Ready/busy synchroniser
   logic                    rb_q, rb_d;          // Filtered ready level
   logic [1:0]              dec_bank;            // Decoded bank of request
   logic                    dec_hit;             // Request hits the open page

   flash_bank_decode u_dec (
      .addr      (req_addr),
      .open_addr (open_q),
      .page_open (popen_q),
      .bank      (dec_bank),
      .page_hit  (dec_hit)
   );

   // Three-stage synchroniser for the asynchronous ready/busy pin
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rb_sync_q <= 3'h7;
      end else begin
         rb_sync_q <= {rb_sync_q[1:0], ready_busy_out};
      end
   end

   // Ready level changes only once stages two and three agree
   always_comb begin
      rb_d = rb_q;
      if (rb_sync_q[1] == rb_sync_q[2]) begin
         rb_d = rb_sync_q[2];
      end
   end

   // Sequencer next state
   always_comb begin
      st_d      = st_q;
      cnt_d     = cnt_q;
      addr_d    = addr_q;
      open_d    = open_q;
      popen_d   = popen_q;
      wd_d      = wd_q;
      rd_d      = rd_q;
      oe_d      = oe_q;
      cs_d      = cs_q;
      rdq_d     = rdq_q;
      wr_d      = wr_q;
      vld_d     = 1'b0;
      rdy_d     = rdy_q;
      bank_d    = bank_q;
      // Pin controls follow the user; reset pin idles the bus
      rst_pin_d = flash_reset_req;
      // Never leave the protect pin floating; high unless guarding is asked
      wp_d      = ~protect_req;
      case (st_q)
         ST_IDLE: begin
            if (req_valid && rdy_q && !flash_reset_req && req_op == OP_READ) begin
               addr_d = req_addr;
               bank_d = dec_bank;
               cs_d   = 1'b1;
               rdq_d  = 1'b1;
               wr_d   = 1'b0;
               oe_d   = 1'b0;
               rdy_d  = 1'b0;
               // Short delay only within the open page
               cnt_d  = dec_hit ? CNT_W'(PACC_CYC) : CNT_W'(ACC_CYC);
               open_d  = req_addr;
               popen_d = 1'b1;
               st_d   = ST_RWAIT;
            end else if (req_valid && rdy_q && !flash_reset_req && req_op == OP_WRITE) begin
               // Output enable drops first so the strobe never meets a read
               addr_d = req_addr;
               wd_d   = req_wdata;
               bank_d = dec_bank;
               rdq_d  = 1'b0;
               cs_d   = 1'b1;
               oe_d   = 1'b1;
               wr_d   = 1'b0;
               rdy_d  = 1'b0;
               popen_d = 1'b0;   // Writes close any page
               cnt_d  = CNT_W'(WP_CYC);
               st_d   = ST_WLOW;
            end else if (flash_reset_req) begin
               // Flash reset returns it to array read; page closed
               cs_d    = 1'b0;
               rdq_d   = 1'b0;
               popen_d = 1'b0;
               rdy_d   = 1'b0;
            end else begin
               // Ready waits one cycle after the flash reset pin rises, as recovery
               rdy_d = !rst_pin_q;
               // Idle deselects, which ends the page
               if (!req_valid) begin
                  cs_d    = 1'b0;
                  rdq_d   = 1'b0;
                  popen_d = 1'b0;
               end
            end
         end
         ST_RWAIT: begin
            if (cnt_q == CNT_ONE) begin
               st_d = ST_RDONE;
            end
            cnt_d = cnt_q - CNT_ONE;
         end
         ST_RDONE: begin
            // Sample data after the access delay; same timing for autoselect
            rd_d  = word_data_lines_i;
            vld_d = 1'b1;
            rdy_d = !(rst_pin_q || flash_reset_req);
            st_d  = ST_IDLE;
         end
         ST_WLOW: begin
            // Strobe low only with output enable high
            wr_d = !rdq_q;
            if (cnt_q == CNT_ONE) begin
               cnt_d = CNT_W'(WPH_CYC);
               st_d  = ST_WHIGH;
            end else begin
               cnt_d = cnt_q - CNT_ONE;
            end
         end
         ST_WHIGH: begin
            // Strobe rises one cycle after entry; select and data hold for the recovery span,
            // so the flash never sees them drop on the latching edge
            wr_d = 1'b0;
            if (cnt_q == CNT_ZERO) begin
               oe_d  = 1'b0;
               cs_d  = 1'b0;
               rdy_d = !(rst_pin_q || flash_reset_req);
               st_d  = ST_IDLE;
            end else begin
               cnt_d = cnt_q - CNT_ONE;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
      // High voltage only while not reading; uses the next output enable level
      hv_d      = accel_req && !rdq_d;
   end

   // Registers; every pin comes straight from one of these
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q      <= ST_IDLE;
         cnt_q     <= CNT_ZERO;
         addr_q    <= '0;
         open_q    <= '0;
         popen_q   <= 1'b0;
         wd_q      <= '0;
         rd_q      <= '0;
         oe_q      <= 1'b0;
         cs_q      <= 1'b0;
         rdq_q     <= 1'b0;
         wr_q      <= 1'b0;
         vld_q     <= 1'b0;
         rdy_q     <= 1'b0;
         bank_q    <= BANK_A;
         rst_pin_q <= 1'b1;
         wp_q      <= 1'b1;
         hv_q      <= 1'b0;
         rb_q      <= 1'b1;
      end else begin
         st_q      <= st_d;
         cnt_q     <= cnt_d;
         addr_q    <= addr_d;
         open_q    <= open_d;
         popen_q   <= popen_d;
         wd_q      <= wd_d;
         rd_q      <= rd_d;
         oe_q      <= oe_d;
         cs_q      <= cs_d;
         rdq_q     <= rdq_d;
         wr_q      <= wr_d;
         vld_q     <= vld_d;
         rdy_q     <= rdy_d;
         bank_q    <= bank_d;
         rst_pin_q <= rst_pin_d;
         wp_q      <= wp_d;
         hv_q      <= hv_d;
         rb_q      <= rb_d;
      end
   end

   assign req_ready          = rdy_q;
   assign rsp_valid          = vld_q;
   assign rsp_rdata          = rd_q;
   assign rsp_bank           = bank_q;
   assign flash_ready        = rb_q;
   assign word_address_lines = addr_q;
   assign chip_sel_n         = ~cs_q;
   assign out_en_n           = ~rdq_q;
   assign wr_strobe_n        = ~wr_q;
   assign reset_n            = ~rst_pin_q;
   assign protect_accel_pin  = wp_q;
   assign accel_high_voltage = hv_q;
   assign word_data_lines_o  = wd_q;
   assign word_data_lines_oe = oe_q;

   localparam int FULL_RSP_CYC = ACC_CYC + 1;  // Wait entry to response, full access
   localparam int PAGE_RSP_CYC = PACC_CYC + 1; // Wait entry to response, in-page access

   // Read cycle shape: select, output enable, no strobe
   sequence read_open_s;
      !chip_sel_n && !out_en_n;
   endsequence

   write_no_read_a: assert property (@(posedge clk_sys) disable iff (rst)
      !wr_strobe_n |-> out_en_n) else $error("strobe low with output enable low");
   write_shape_a: assert property (@(posedge clk_sys) disable iff (rst)
      !wr_strobe_n |-> !chip_sel_n && word_data_lines_oe) else $error("bad write");
   read_shape_a: assert property (@(posedge clk_sys) disable iff (rst)
      read_open_s |-> wr_strobe_n && !word_data_lines_oe) else $error("bad read");
   read_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
      ($rose(st_q == ST_RWAIT) && cnt_q == CNT_W'(ACC_CYC)) |-> ##(FULL_RSP_CYC) rsp_valid)
      else $error("full access wait wrong");
   page_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
      ($rose(st_q == ST_RWAIT) && cnt_q == CNT_W'(PACC_CYC)) |-> ##(PAGE_RSP_CYC) rsp_valid)
      else $error("page access wait wrong");
   page_close_a: assert property (@(posedge clk_sys) disable iff (rst)
      chip_sel_n |-> !popen_q) else $error("page open while deselected");
   hv_read_a: assert property (@(posedge clk_sys) disable iff (rst)
      !out_en_n |-> !accel_high_voltage) else $error("high voltage during read");
   reset_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
      !reset_n |-> ##1 !req_ready) else $error("ready during flash reset");
   protect_drv_a: assert property (@(posedge clk_sys) disable iff (rst)
      protect_req |=> !protect_accel_pin) else $error("protect pin not low");
endmodule

// ---- sim/flash_dev_model.sv ----
// Purpose: Behavioural model of the parallel flash behind the host controller.
// Assumes: Array content is a fixed pattern of the address; a few commands only.
// Notes:   Released data lines show the inverse of the last read word, never a hold.
`timescale 1ns/1ps
module flash_dev_model
   import flash_host_pkg::*;
#(
   parameter logic [15:0] ID_CODE = 16'h0C5A  // Arbitrary identification value
)(
   input  wire logic [flash_host_pkg::ADDR_W-1:0] word_address_lines, // Address pins
   input  wire logic                              chip_sel_n,         // Select, low active
   input  wire logic                              out_en_n,           // Output enable
   input  wire logic                              wr_strobe_n,        // Write strobe
   input  wire logic                              reset_n,            // Reset pin
   input  wire logic                              protect_accel_pin,  // Edge guard pin
   input  wire logic                              accel_high_voltage, // High voltage on
   input  wire logic [flash_host_pkg::DATA_W-1:0] word_data_lines_o,  // Host data
   input  wire logic                              word_data_lines_oe, // Host drives
   output logic      [flash_host_pkg::DATA_W-1:0] dq_wire,            // Resolved data wire
   output logic                                   rb_wire             // Pulled-up busy line
);
   logic [15:0] mem [logic [22:0]];  // Programmed words
   logic [19:0] page_q;              // Open page
   logic        page_ok = 0;         // A page is open
   logic        rd_vld = 0;          // Access delay elapsed
   logic        auto_q = 0;          // Identification mode
   logic        prog_q = 0;          // Next write is program data
   logic        byp_q = 0;           // Short program mode
   logic [1:0]  unl_q = 0;           // Unlock progress
   logic [15:0] rd_d;                // Word the device would show
   logic [15:0] last_d = 0;          // Last word shown
   time         t_chg = 0;           // Last address or select change
   time         busy_end = 0;        // End of embedded program
   // Any change restarts the access; slower than real, never faster
   always @(word_address_lines or chip_sel_n or out_en_n or reset_n) t_chg = $time;
   // Fine time step evaluation of access delay, page and reset state
   always #1 begin
      if (chip_sel_n || !reset_n) page_ok = 0;
      rd_vld = !chip_sel_n && !out_en_n && reset_n && ($time - t_chg >=
         ((page_ok && word_address_lines[22:3] == page_q) ? T_PACC_NS : T_ACC_NS));
      if (rd_vld) begin
         page_ok = 1;
         page_q = word_address_lines[22:3];
         last_d = rd_d;
      end
      if (!reset_n) begin
         auto_q = 0;
         prog_q = 0;
         byp_q = 0;
         unl_q = 0;
      end
      rb_wire = !($time < busy_end || !reset_n);
   end
   // Reads ignore program activity in any bank
   always @* begin
      if (auto_q) rd_d = ID_CODE;
      else if (mem.exists(word_address_lines)) rd_d = mem[word_address_lines];
      else rd_d = word_address_lines[15:0] ^ {word_address_lines[22:20], 13'h1A3C};
   end
   // Float when not reading: inverse of last word stands for high impedance
   always @* dq_wire = word_data_lines_oe ? word_data_lines_o : rd_vld ? rd_d : ~last_d;
   // Command cycle is latched at the strobe rise; strobes during a read are dropped
   always @(posedge wr_strobe_n) begin
      if (!chip_sel_n && out_en_n && reset_n) begin
         if (prog_q) begin
            prog_q = 0;
            if (protect_accel_pin || (word_address_lines >= 23'h2000
                && word_address_lines < 23'h7FE000)) begin
               mem[word_address_lines] = word_data_lines_o;
               busy_end = $time + 2000;
            end
         end
         else if (word_data_lines_o == 16'hF0) {auto_q, unl_q} = 0;
         else if (unl_q == 0 && word_data_lines_o == 16'hAA) unl_q = 1;
         else if (unl_q == 1 && word_data_lines_o == 16'h55) unl_q = 2;
         else if (word_data_lines_o == 16'hA0 && (unl_q == 2 || byp_q || accel_high_voltage))
            {prog_q, unl_q} = 3'h4;
         else if (unl_q == 2 && word_data_lines_o == 16'h90) {auto_q, unl_q} = 3'h4;
         else if (unl_q == 2 && word_data_lines_o == 16'h20) {byp_q, unl_q} = 3'h4;
         else if (unl_q == 2 && word_data_lines_o == 16'h10) begin
            // Whole-array erase, kept to one step after unlock
            mem.delete();
            unl_q = 0;
            busy_end = $time + 2000;
         end
         else unl_q = 0;
      end
   end
endmodule

// ---- sim/flash_async_bus_interface_tb_top.sv ----
// Purpose: Self-checking bench of the flash host controller against a device model.
// Assumes: Inputs change 1 ns after the rising edge; reset held 16 cycles.
// Notes:   Pin monitor checks select levels on every rising clock edge with the strobe or output enable low.
`timescale 1ns/1ps
module flash_async_bus_interface_tb_top;
   import flash_host_pkg::*;
   localparam logic [15:0] ID_CODE = 16'h0C5A; // Arbitrary identification value
   typedef struct packed {logic [22:0] a; logic [1:0] bank; logic [3:0] lat;} row_type;
   logic clk_sys = 0, rst = 1, req_valid = 0, accel_req = 0, protect_req = 0;
   logic flash_reset_req = 0, req_ready, rsp_valid, flash_ready, chip_sel_n, out_en_n;
   logic wr_strobe_n, reset_n, protect_accel_pin, accel_high_voltage, word_data_lines_oe;
   logic rb_wire;
   op_type req_op = OP_NONE;
   logic [22:0] req_addr = 0, word_address_lines;
   logic [15:0] req_wdata = 0, rsp_rdata, word_data_lines_o, dq_wire;
   logic [1:0] rsp_bank;
   int mismatches = 0, cmp_count = 0, cyc = 0;
   // Bank codes, page hits and misses; reads run back to back
   row_type rows [11] = '{'{23'h000000, 2'h0, 4'h5}, '{23'h000007, 2'h0, 4'h3},
      '{23'h000008, 2'h0, 4'h5}, '{23'h100003, 2'h1, 4'h5}, '{23'h200000, 2'h1, 4'h5},
      '{23'h300000, 2'h1, 4'h5}, '{23'h400000, 2'h2, 4'h5}, '{23'h500000, 2'h2, 4'h5},
      '{23'h600000, 2'h2, 4'h5}, '{23'h700005, 2'h3, 4'h5}, '{23'h700002, 2'h3, 4'h3}};
   flash_host_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .req_op(req_op),
      .req_valid(req_valid), .req_addr(req_addr), .req_wdata(req_wdata),
      .accel_req(accel_req), .protect_req(protect_req), .flash_reset_req(flash_reset_req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .rsp_bank(rsp_bank), .flash_ready(flash_ready), .word_address_lines(word_address_lines),
      .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
      .reset_n(reset_n), .protect_accel_pin(protect_accel_pin),
      .accel_high_voltage(accel_high_voltage), .word_data_lines_o(word_data_lines_o),
      .word_data_lines_oe(word_data_lines_oe), .word_data_lines_i(dq_wire),
      .ready_busy_out(rb_wire));
   flash_dev_model #(.ID_CODE(ID_CODE)) model_u (.word_address_lines(word_address_lines),
      .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
      .reset_n(reset_n), .protect_accel_pin(protect_accel_pin),
      .accel_high_voltage(accel_high_voltage), .word_data_lines_o(word_data_lines_o),
      .word_data_lines_oe(word_data_lines_oe), .dq_wire(dq_wire), .rb_wire(rb_wire));
   // 40 MHz system clock
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   function automatic logic [15:0] pat(input logic [22:0] a);
      return a[15:0] ^ {a[22:20], 13'h1A3C};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // One-cycle request once the controller shows ready
   task automatic issue(input op_type op, input logic [22:0] a, input logic [15:0] d);
      while (req_ready !== 1'b1) begin
         @(posedge clk_sys);
         #1;
      end
      req_op = op;
      {req_addr, req_wdata, req_valid} = {a, d, 1'b1};
      @(posedge clk_sys);
      #1;
      req_op = OP_NONE;
      req_valid = 1'b0;
   endtask
   task automatic wr(input logic [22:0] a, input logic [15:0] d);
      issue(OP_WRITE, a, d);
      @(posedge clk_sys);
      #1;
   endtask
   task automatic prog(input logic [22:0] a, input logic [15:0] d);
      wr(23'h555, 16'hAA);
      wr(23'h2AA, 16'h55);
      wr(23'h555, 16'hA0);
      wr(a, d);
   endtask
   // Read and count edges from take to the response pulse
   task automatic do_read(input logic [22:0] a, input int lat, input logic [15:0] exp_d);
      int k;
      k = 0;
      issue(OP_READ, a, 16'h0);
      while (rsp_valid !== 1'b1 && k < 30) begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      check(k, lat);
      check(rsp_rdata, exp_d);
   endtask
   task automatic wait_ready();
      int k;
      k = 0;
      while (flash_ready !== 1'b1 && k < 300) begin
         @(posedge clk_sys);
         k++;
      end
      #1;
   endtask
   // Pin monitor and hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc > 6000) begin
         mismatches++;
         give_verdict();
      end
      if (!rst && wr_strobe_n === 1'b0)
         check({chip_sel_n, out_en_n, word_data_lines_oe}, 3'b011);
      if (!rst && out_en_n === 1'b0)
         check({wr_strobe_n, chip_sel_n, word_data_lines_oe}, 3'b100);
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      #1;
      check({chip_sel_n, out_en_n, wr_strobe_n, reset_n, protect_accel_pin,
             accel_high_voltage, word_data_lines_oe, req_ready}, 8'hE8);
      rst = 0;
      for (int i = 0; i < 11; i++) begin
         do_read(rows[i].a, rows[i].lat, pat(rows[i].a));
         check(rsp_bank, rows[i].bank);
      end
      @(posedge clk_sys);
      #1;
      do_read(23'h700003, 5, pat(23'h700003));
      wr(23'h555, 16'hAA);
      wr(23'h2AA, 16'h55);
      wr(23'h555, 16'h90);
      do_read(23'h100000, 5, ID_CODE);
      wr(23'h0, 16'hF0);
      do_read(23'h100000, 5, pat(23'h100000));
      wr(23'h555, 16'hAA);
      wr(23'h2AA, 16'h55);
      wr(23'h555, 16'h90);
      do_read(23'h100000, 5, ID_CODE);
      flash_reset_req = 1;
      repeat (2) @(posedge clk_sys);
      #1;
      check(reset_n, 1'b0);
      flash_reset_req = 0;
      repeat (2) @(posedge clk_sys);
      #1;
      do_read(23'h100001, 5, pat(23'h100001));
      prog(23'h000040, 16'hBEEF);
      repeat (12) @(posedge clk_sys);
      #1;
      check(flash_ready, 1'b0);
      do_read(23'h700010, 5, pat(23'h700010));
      wait_ready();
      check(flash_ready, 1'b1);
      do_read(23'h000040, 5, 16'hBEEF);
      accel_req = 1;
      repeat (2) @(posedge clk_sys);
      #1;
      check(accel_high_voltage, 1'b1);
      do_read(23'h200100, 5, pat(23'h200100));
      wr(23'h200100, 16'hA0);
      wr(23'h200100, 16'h1234);
      accel_req = 0;
      wait_ready();
      do_read(23'h200100, 5, 16'h1234);
      protect_req = 1;
      repeat (2) @(posedge clk_sys);
      #1;
      check(protect_accel_pin, 1'b0);
      prog(23'h000100, 16'h4321);
      do_read(23'h000100, 5, pat(23'h000100));
      give_verdict();
   end
endmodule
